// [hw/exec_pkg.sv]
package exec_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  // one machine cycle spans four core clocks
  localparam int MACHINE_CLKS = 4;
  localparam int DIV_W = 2;
  localparam logic [DIV_W-1:0] TICK_AT = 2'h3;

  // ****************************************************************
  // widths and memory map
  // ****************************************************************
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int MEM_AW = 5;
  localparam int MEM_DEPTH = 32;
  localparam logic [MEM_AW-1:0] PC_LOW_ADDR = 5'h02;

  // ****************************************************************
  // register bus map, byte addresses
  // ****************************************************************
  localparam int BUS_AW = 8;
  localparam logic [BUS_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [BUS_AW-1:0] REG_ACC = 8'h04;
  localparam logic [BUS_AW-1:0] REG_FLAGS = 8'h08;
  localparam logic [BUS_AW-1:0] REG_PC = 8'h0c;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_BUSY_BIT = 8;
  localparam int FLAGS_W = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic RUN_RESET = 1'b1;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ADC_ACC = 4'h1,
    OP_ADC_MEM = 4'h2,
    OP_ADD_ACC = 4'h3,
    OP_ADD_IMM = 4'h4,
    OP_ADD_MEM = 4'h5,
    OP_AND_ACC = 4'h6,
    OP_AND_IMM = 4'h7,
    OP_AND_MEM = 4'h8,
    OP_CALL = 4'h9,
    OP_CLR_MEM = 4'ha
  } op_type;

  typedef struct packed {
    op_type op;
    logic [MEM_AW-1:0] memAddr;
    logic [DATA_W-1:0] imm;
    logic [PC_W-1:0] target;
  } instr_type;

  // bit order matches the flags register: sv z hc c, c in bit 0
  typedef struct packed {
    logic sv;
    logic z;
    logic hc;
    logic c;
  } flags_type;

  localparam flags_type FLAGS_RESET = 4'h0;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_EXEC = 3'b010,
    S_EXTRA = 3'b100
  } state_type;

endpackage

// [hw/phase_tick.sv]
`timescale 1ns/1ps
module phase_tick (
  input wire logic sys_clk,
  input wire logic rst_b,
  output logic tick
);
  import exec_pkg::*;

  logic [DIV_W-1:0] countReg;
  logic tickReg;

  // free running phase counter, wraps every machine cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      countReg <= '0;
    end else begin
      countReg <= countReg + 1'b1;
    end
  end

  // registered so the enable is glitch free for every user
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tickReg <= 1'b0;
    end else begin
      tickReg <= (countReg == TICK_AT);
    end
  end

  assign tick = tickReg;
endmodule

// [hw/data_store.sv]
`timescale 1ns/1ps
module data_store (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wrEn,
  input wire logic [exec_pkg::MEM_AW-1:0] wrAddr,
  input wire logic [exec_pkg::DATA_W-1:0] wrData,
  input wire logic [exec_pkg::MEM_AW-1:0] rdAddr,
  output logic [exec_pkg::DATA_W-1:0] rdData
);
  import exec_pkg::*;

  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [DATA_W-1:0] rdReg;

  // storage has no reset, contents are undefined at power up
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // read data from a register, old data on a same-edge write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdReg <= ZERO_BYTE;
    end else begin
      rdReg <= mem[rdAddr];
    end
  end

  assign rdData = rdReg;
endmodule

// [hw/exec_unit.sv]
// What this block does
// - add with carry to the working register sums it, the memory byte and carry, and sets all four arithmetic flags.
// - add with carry into memory sums the same three terms and writes the byte back, setting all four flags.
// - plain add from memory sums the memory byte into the working register without carry and sets all four flags.
// - immediate add sums the literal into the working register without carry and sets all four flags.
// - plain add into memory writes working register plus memory byte back to memory and sets all four flags.
// - and with memory leaves the bitwise product in the working register and touches only the nil flag.
// - and with a literal leaves the bitwise product in the working register and touches only the nil flag.
// - and into memory writes the bitwise product back to memory and touches only the nil flag.
// - a call pushes program counter plus one, loads the target address and leaves every flag alone.
// - a call occupies two machine cycles.
// - byte zeroing writes 00h into the addressed memory byte.
// - any result written into the program counter low byte costs two machine cycles.
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module exec_unit (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic issueValid,
  input wire exec_pkg::instr_type issueInstr,
  output logic issueReady,
  output logic doneStrobe,
  output logic stackPush,
  output logic [exec_pkg::PC_W-1:0] stackPushAddr,
  output logic [exec_pkg::PC_W-1:0] pcValue,
  output exec_pkg::flags_type flagsValue,
  output logic [exec_pkg::DATA_W-1:0] workingRegister,
  input wire logic [exec_pkg::BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import exec_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  state_type stateReg;
  instr_type instrReg;
  flags_type flagsReg;
  logic [DATA_W-1:0] accReg;
  logic [PC_W-1:0] pcReg;
  logic [PC_W-1:0] pushAddrReg;
  logic pushReg;
  logic doneReg;
  logic runReg;
  logic ackReg;
  logic [31:0] rdDataReg;
  logic tick;
  logic accept;
  logic execTick;
  logic lowHit;
  logic lowWrite;
  logic twoCycle;
  logic [DATA_W-1:0] memRdData;
  logic [DATA_W-1:0] opndM;
  logic [DATA_W-1:0] opndB;
  logic cin;
  logic isSum;
  logic isAnd;
  logic toMem;
  logic [DATA_W:0] sumFull;
  logic [4:0] halfSum;
  logic overflow;
  logic [DATA_W-1:0] result;
  logic memWe;
  logic busReq;
  logic grant;
  logic busWrLo;
  logic busWrHi;

  // ****************************************************************
  // machine cycle enable and data memory
  // ****************************************************************
  phase_tick u_tick (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .tick(tick)
  );

  // pc low byte lives in the counter, so memory never sees it
  assign memWe = execTick & toMem & ~lowHit;

  data_store u_store (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wrEn(memWe),
    .wrAddr(instrReg.memAddr),
    .wrData(result),
    .rdAddr(instrReg.memAddr),
    .rdData(memRdData)
  );

  // ****************************************************************
  // sequencing
  // ****************************************************************
  // a pending bus write holds off issue so the two never collide
  assign lowHit = (instrReg.memAddr == PC_LOW_ADDR);
  assign lowWrite = toMem & lowHit;
  assign twoCycle = (instrReg.op == OP_CALL) | lowWrite;
  assign execTick = (stateReg == S_EXEC) & tick;
  assign issueReady = tick & runReg & ~avs_write
    & ((stateReg == S_IDLE) | ((stateReg == S_EXEC) & ~twoCycle));
  assign accept = issueValid & issueReady;

  // one-cycle ops chain back to back, two-cycle ops park in extra
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateReg <= S_IDLE;
    end else begin
      case (stateReg)
        S_IDLE: begin
          if (accept) begin
            stateReg <= S_EXEC;
          end
        end
        S_EXEC: begin
          if (tick) begin
            if (twoCycle) begin
              stateReg <= S_EXTRA;
            end else if (!accept) begin
              stateReg <= S_IDLE;
            end
          end
        end
        S_EXTRA: begin
          if (tick) begin
            stateReg <= S_IDLE;
          end
        end
        default: begin
          stateReg <= S_IDLE;
        end
      endcase
    end
  end

  // instruction held for the whole execution
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      instrReg <= '0;
    end else if (accept) begin
      instrReg <= issueInstr;
    end
  end

  // ****************************************************************
  // datapath
  // ****************************************************************
  // reading the pc low byte returns the live counter
  assign opndM = lowHit ? pcReg[DATA_W-1:0] : memRdData;

  // operand and destination select per operation
  always_comb begin
    opndB = opndM;
    cin = 1'b0;
    isSum = 1'b0;
    isAnd = 1'b0;
    toMem = 1'b0;
    case (instrReg.op)
      OP_ADC_ACC: begin
        isSum = 1'b1;
        cin = flagsReg.c;
      end
      OP_ADC_MEM: begin
        isSum = 1'b1;
        cin = flagsReg.c;
        toMem = 1'b1;
      end
      OP_ADD_ACC: begin
        isSum = 1'b1;
      end
      OP_ADD_IMM: begin
        isSum = 1'b1;
        opndB = instrReg.imm;
      end
      OP_ADD_MEM: begin
        isSum = 1'b1;
        toMem = 1'b1;
      end
      OP_AND_ACC: begin
        isAnd = 1'b1;
      end
      OP_AND_IMM: begin
        isAnd = 1'b1;
        opndB = instrReg.imm;
      end
      OP_AND_MEM: begin
        isAnd = 1'b1;
        toMem = 1'b1;
      end
      OP_CLR_MEM: begin
        toMem = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // full and nibble adders give carry and half carry directly
  assign sumFull = {1'b0, accReg} + {1'b0, opndB} + {8'h00, cin};
  assign halfSum = {1'b0, accReg[3:0]} + {1'b0, opndB[3:0]}
    + {4'h0, cin};
  assign overflow = (accReg[7] == opndB[7])
    & (sumFull[7] != accReg[7]);
  // zeroing falls through to the zero byte
  assign result = isSum ? sumFull[DATA_W-1:0]
    : (isAnd ? (accReg & opndB) : ZERO_BYTE);

  // ****************************************************************
  // architectural state
  // ****************************************************************
  // working register, bus writes only land while idle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      accReg <= ACC_RESET;
    end else if (busWrLo && avs_address == REG_ACC) begin
      accReg <= avs_writedata[DATA_W-1:0];
    end else if (execTick && (isSum || isAnd) && !toMem) begin
      accReg <= result;
    end
  end

  // logic ops touch only z, calls and zeroing touch none
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flagsReg <= FLAGS_RESET;
    end else if (busWrLo && avs_address == REG_FLAGS) begin
      flagsReg <= avs_writedata[FLAGS_W-1:0];
    end else if (execTick && isSum) begin
      flagsReg.sv <= overflow;
      flagsReg.z <= (result == ZERO_BYTE);
      flagsReg.hc <= halfSum[4];
      flagsReg.c <= sumFull[DATA_W];
    end else if (execTick && isAnd) begin
      flagsReg.z <= (result == ZERO_BYTE);
    end
  end

  // program counter, low byte writes keep the page bits
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pcReg <= PC_RESET;
    end else if (busWrLo && avs_address == REG_PC) begin
      pcReg <= {busWrHi ? avs_writedata[PC_W-1:DATA_W]
        : pcReg[PC_W-1:DATA_W], avs_writedata[DATA_W-1:0]};
    end else if (execTick) begin
      if (instrReg.op == OP_CALL) begin
        pcReg <= instrReg.target;
      end else if (lowWrite) begin
        pcReg <= {pcReg[PC_W-1:DATA_W], result};
      end else begin
        pcReg <= pcReg + 1'b1;
      end
    end
  end

  // return address goes out with a one-cycle push strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pushReg <= 1'b0;
      pushAddrReg <= PC_RESET;
    end else begin
      pushReg <= execTick & (instrReg.op == OP_CALL);
      if (execTick && instrReg.op == OP_CALL) begin
        pushAddrReg <= pcReg + 1'b1;
      end
    end
  end

  // completion strobe, second machine cycle for two-cycle ops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      doneReg <= 1'b0;
    end else begin
      doneReg <= (execTick & ~twoCycle)
        | ((stateReg == S_EXTRA) & tick);
    end
  end

  // ****************************************************************
  // register bus slave
  // ****************************************************************
  // one wait cycle; writes also wait for the unit to go idle
  assign busReq = avs_read | avs_write;
  assign grant = busReq & ~ackReg & (avs_read | (stateReg == S_IDLE));
  assign avs_waitrequest = busReq & ~ackReg;
  assign busWrLo = avs_write & ackReg & avs_byteenable[0];
  assign busWrHi = avs_byteenable[1];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ackReg <= 1'b0;
    end else begin
      ackReg <= grant;
    end
  end

  // run bit gates issue, so software can freeze the unit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      runReg <= RUN_RESET;
    end else if (busWrLo && avs_address == REG_CTRL) begin
      runReg <= avs_writedata[CTRL_RUN_BIT];
    end
  end

  // read data captured at grant, unmapped reads return zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdDataReg <= 32'h0000_0000;
    end else if (grant && avs_read) begin
      if (avs_address == REG_CTRL) begin
        rdDataReg <= 32'h0000_0000;
        rdDataReg[CTRL_RUN_BIT] <= runReg;
        rdDataReg[CTRL_BUSY_BIT] <= (stateReg != S_IDLE);
      end else if (avs_address == REG_ACC) begin
        rdDataReg <= {24'h00_0000, accReg};
      end else if (avs_address == REG_FLAGS) begin
        rdDataReg <= {28'h000_0000, flagsReg};
      end else if (avs_address == REG_PC) begin
        rdDataReg <= {21'h00_0000, pcReg};
      end else begin
        rdDataReg <= 32'h0000_0000;
      end
    end
  end

  assign avs_readdata = rdDataReg;
  assign stackPush = pushReg;
  assign stackPushAddr = pushAddrReg;
  assign pcValue = pcReg;
  assign flagsValue = flagsReg;
  assign workingRegister = accReg;
  assign doneStrobe = doneReg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  chk_adc_working: assert property (
    execTick && instrReg.op == OP_ADC_ACC |=>
      accReg == DATA_W'($past(accReg) + $past(opndM) + $past(flagsReg.c)))
    else $error("add with carry to working register wrong");

  chk_adc_memory: assert property (
    execTick && instrReg.op == OP_ADC_MEM && !lowHit |->
      memWe && result == DATA_W'(accReg + memRdData + flagsReg.c))
    else $error("add with carry into memory wrong");

  chk_add_plain: assert property (
    execTick && instrReg.op == OP_ADD_ACC |=>
      accReg == DATA_W'($past(accReg) + $past(opndM))
      && stateReg != S_EXTRA)
    else $error("plain add to working register wrong");

  chk_add_literal: assert property (
    execTick && instrReg.op == OP_ADD_IMM |=>
      accReg == DATA_W'($past(accReg) + $past(instrReg.imm)))
    else $error("immediate add wrong");

  chk_add_memory: assert property (
    execTick && instrReg.op == OP_ADD_MEM && !lowHit |->
      memWe && result == DATA_W'(accReg + memRdData)
      ##1 $stable(accReg))
    else $error("plain add into memory wrong");

  chk_and_flags: assert property (
    execTick && isAnd |=> $stable(flagsReg.c) && $stable(flagsReg.hc)
      && $stable(flagsReg.sv) && flagsReg.z == ($past(result) == 8'h00))
    else $error("and op disturbed a flag");

  chk_and_memory: assert property (
    execTick && instrReg.op == OP_AND_MEM && !lowHit |->
      memWe && result == (accReg & memRdData))
    else $error("and into memory wrong");

  chk_call_push: assert property (
    execTick && instrReg.op == OP_CALL |=> stackPush
      && stackPushAddr == PC_W'($past(pcReg) + 1)
      && pcReg == $past(instrReg.target) && $stable(flagsReg))
    else $error("call push or target wrong");

  chk_call_two: assert property (
    execTick && instrReg.op == OP_CALL |=>
      (stateReg == S_EXTRA && !doneStrobe) [*4] ##1 doneStrobe)
    else $error("call not two machine cycles");

  chk_clear_zero: assert property (
    execTick && instrReg.op == OP_CLR_MEM && !lowHit |->
      memWe && result == 8'h00)
    else $error("byte zeroing wrote nonzero");

  chk_low_two: assert property (
    execTick && lowWrite |=>
      pcReg[7:0] == $past(result) ##0 (stateReg == S_EXTRA) [*4]
      ##1 stateReg != S_EXTRA)
    else $error("pc low byte write not two machine cycles");

  chk_carry_out: assert property (
    execTick && isSum |=> flagsReg.c == ($past(sumFull) > 9'h0ff)
      && flagsReg.hc == ($past(halfSum) > 5'h0f))
    else $error("carry or half carry wrong");
endmodule

// [test/mcu_add_and_call_clear_exec_test.sv]
`timescale 1ns/1ps
module mcu_add_and_call_clear_exec_test;
  import exec_pkg::*;
  typedef struct {
    logic [7:0] acc;
    flags_type fl;
    logic [10:0] pc;
    int due;
  } exp_type;
  logic sys_clk, rst_b, issueValid, issueReady, doneStrobe, stackPush;
  instr_type issueInstr;
  logic [10:0] stackPushAddr, pcValue;
  flags_type flagsValue;
  logic [7:0] workingRegister, avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  // reference state kept by the drivers
  logic [7:0] acc;
  flags_type fl;
  logic [10:0] pc;
  logic [7:0] mem [32];
  exp_type expQ[$];
  logic [10:0] pushQ[$];
  exp_type ex;
  int cyc, n_mismatch, n_checks, k;
  op_type opList[10] = '{OP_ADC_ACC, OP_ADC_MEM, OP_ADD_ACC, OP_ADD_IMM,
    OP_ADD_MEM, OP_AND_ACC, OP_AND_IMM, OP_AND_MEM, OP_CLR_MEM, OP_NOP};

  exec_unit exec_unit_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .issueValid(issueValid), .issueInstr(issueInstr),
    .issueReady(issueReady), .doneStrobe(doneStrobe),
    .stackPush(stackPush), .stackPushAddr(stackPushAddr),
    .pcValue(pcValue), .flagsValue(flagsValue),
    .workingRegister(workingRegister), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // ****************************************************************
  // clock, cycle count, checking helpers
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2.0) sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic fail(input string msg);
    n_mismatch++;
    $display("[FAIL] %0t ns: %s", $time, msg);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // sum with flags packed above the result byte
  function automatic logic [11:0] addf(input logic [7:0] a,
      input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    flags_type f;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    f.c = s[8];
    f.hc = h[4];
    f.z = (s[7:0] == 8'h00);
    f.sv = (a[7] == b[7]) && (s[7] != a[7]);
    return {f, s[7:0]};
  endfunction

  // ****************************************************************
  // avalon master: hold until waitrequest is seen low, then release
  // ****************************************************************
  task automatic bus(input logic wr, input logic [7:0] addr,
      input logic [31:0] wd, input logic [3:0] be, output logic [31:0] rd);
    int j;
    @(posedge sys_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= addr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    for (j = 0; j < 200; j++) begin
      #1;
      if (avs_waitrequest === 1'b0) break;
      @(posedge sys_clk);
    end
    if (j == 200) fail("bus hang");
    rd = avs_readdata;
    @(posedge sys_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // lane 0 gates every write, lane 1 the top pc bits
    if (wr && be[0]) begin
      case (addr)
        REG_ACC: acc = wd[7:0];
        REG_FLAGS: fl = wd[3:0];
        REG_PC: begin
          pc[7:0] = wd[7:0];
          if (be[1]) pc[10:8] = wd[10:8];
        end
        default: ;
      endcase
    end
  endtask

  task automatic bw(input logic [7:0] addr, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, addr, d, 4'hf, x);
  endtask

  task automatic rc(input logic [7:0] addr, input logic [31:0] want);
    logic [31:0] x;
    bus(1'b0, addr, 32'h0, 4'hf, x);
    check(x, want);
  endtask

  // ****************************************************************
  // issue driver: offer until taken, then note the expected outcome
  // ****************************************************************
  task automatic issue(input op_type op, input logic [4:0] a,
      input logic [7:0] imm, input logic [10:0] tgt);
    int j;
    exp_type e;
    logic [7:0] opnd;
    logic [11:0] r;
    logic memDst;
    @(posedge sys_clk);
    issueValid <= 1'b1;
    issueInstr <= '{op: op, memAddr: a, imm: imm, target: tgt};
    for (j = 0; j < 50; j++) begin
      #1;
      if (issueReady === 1'b1) break;
      @(posedge sys_clk);
    end
    if (j == 50) fail("issue hang");
    @(posedge sys_clk);
    issueValid <= 1'b0;
    #1;
    opnd = (a == PC_LOW_ADDR) ? pc[7:0] : mem[a];
    r = {fl, 8'h00};
    case (op)
      OP_ADC_ACC, OP_ADC_MEM: r = addf(acc, opnd, fl.c);
      OP_ADD_ACC, OP_ADD_MEM: r = addf(acc, opnd, 1'b0);
      OP_ADD_IMM: r = addf(acc, imm, 1'b0);
      OP_AND_ACC, OP_AND_MEM:
        r = {fl.sv, (acc & opnd) == 8'h00, fl.hc, fl.c, acc & opnd};
      OP_AND_IMM: r = {fl.sv, (acc & imm) == 8'h00, fl.hc, fl.c, acc & imm};
      default: ;
    endcase
    fl = r[11:8];
    memDst = op inside {OP_ADC_MEM, OP_ADD_MEM, OP_AND_MEM, OP_CLR_MEM};
    if (op inside {OP_ADC_ACC, OP_ADD_ACC, OP_ADD_IMM, OP_AND_ACC,
        OP_AND_IMM}) acc = r[7:0];
    e.due = cyc + 4;
    if (op == OP_CALL) begin
      pushQ.push_back(pc + 11'h001);
      pc = tgt;
      e.due = cyc + 8;
    end else if (memDst && a == PC_LOW_ADDR) begin
      // a result aimed at the low pc byte costs a second cycle
      pc[7:0] = r[7:0];
      e.due = cyc + 8;
    end else begin
      if (memDst) mem[a] = r[7:0];
      pc = pc + 11'h001;
    end
    e.acc = acc;
    e.fl = fl;
    e.pc = pc;
    expQ.push_back(e);
  endtask

  // ****************************************************************
  // output watcher, sampled mid-cycle where outputs have settled
  // ****************************************************************
  always @(negedge sys_clk) begin
    if (rst_b === 1'b1 && stackPush === 1'b1) begin
      if (pushQ.size() == 0) fail("unexpected push");
      else check(32'(stackPushAddr), 32'(pushQ.pop_front()));
    end
    if (rst_b === 1'b1 && doneStrobe === 1'b1) begin
      if (expQ.size() == 0) fail("unexpected done");
      else begin
        ex = expQ.pop_front();
        check(32'(workingRegister), 32'(ex.acc));
        check(32'(flagsValue), 32'(ex.fl));
        check(32'(pcValue), 32'(ex.pc));
        check(cyc, ex.due);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail("watchdog expired");
    print_verdict();
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    issueValid = 1'b0;
    issueInstr = '0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'h0;
    {cyc, n_mismatch, n_checks} = '0;
    acc = ACC_RESET;
    fl = FLAGS_RESET;
    pc = PC_RESET;
    void'($urandom(32'h96241c5b));
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    // reset values, unmapped and lane-0-less writes ignored
    rc(REG_CTRL, 32'h00000001);
    rc(REG_FLAGS, 32'h0);
    rc(REG_PC, 32'h0);
    bw(8'h10, 32'hff);
    bus(1'b1, REG_ACC, 32'h55, 4'he, ex.due);
    rc(8'h10, 32'h0);
    rc(REG_ACC, 32'h0);
    $display("test registers done");
    // zero bytes 3 to 31, then load a few through a plain sum
    for (k = 3; k < 32; k++) issue(OP_CLR_MEM, 5'(k), 8'h00, 11'h0);
    for (k = 0; k < 8; k++) begin
      bw(REG_ACC, 32'($urandom));
      issue(OP_ADD_MEM, 5'($urandom_range(31, 3)), 8'h00, 11'h0);
    end
    $display("test memory load done");
    // boundary sums: overflow, carry to zero, half carry, carry in
    for (k = 0; k < 5; k++) begin
      bw(REG_ACC, 32'(8'h7f + 8'(k * 64)));
      bw(REG_FLAGS, 32'(k[0]));
      issue(k[0] ? OP_ADC_ACC : OP_ADD_IMM, 5'h03, 8'h81 - 8'(k), 11'h0);
    end
    $display("test boundary sums done");
    // random mix of every data op back to back
    for (k = 0; k < 60; k++) begin
      if ($urandom_range(3) == 0) bw(REG_FLAGS, 32'($urandom_range(15)));
      if ($urandom_range(3) == 0) bw(REG_ACC, 32'($urandom));
      issue(opList[$urandom_range(9)], 5'($urandom_range(31, 3)),
        8'($urandom), 11'h0);
    end
    $display("test random ops done");
    // calls back to back; busy is visible while the first runs
    issue(OP_CALL, 5'h00, 8'h00, 11'($urandom));
    rc(REG_CTRL, 32'h00000101);
    issue(OP_CALL, 5'h00, 8'h00, 11'h7ff);
    $display("test calls done");
    // the pc low byte as an operand, then results aimed at it
    bw(REG_ACC, 32'h21);
    issue(OP_ADD_ACC, PC_LOW_ADDR, 8'h00, 11'h0);
    issue(OP_ADD_MEM, PC_LOW_ADDR, 8'h00, 11'h0);
    issue(OP_ADC_MEM, PC_LOW_ADDR, 8'h00, 11'h0);
    issue(OP_AND_MEM, PC_LOW_ADDR, 8'h00, 11'h0);
    issue(OP_CLR_MEM, PC_LOW_ADDR, 8'h00, 11'h0);
    $display("test pc low byte writes done");
    // with run cleared nothing may be taken
    bw(REG_CTRL, 32'h0);
    repeat (12) begin
      @(posedge sys_clk);
      #1;
      check(32'(issueReady), 32'h0);
    end
    bw(REG_CTRL, 32'h1);
    issue(OP_NOP, 5'h03, 8'h00, 11'h0);
    $display("test run bit done");
    for (k = 0; k < 100 && expQ.size() > 0; k++) @(posedge sys_clk);
    check(32'(expQ.size() + pushQ.size()), 32'h0);
    rc(REG_ACC, 32'(acc));
    rc(REG_FLAGS, 32'(fl));
    rc(REG_PC, 32'(pc));
    $display("test readback done");
    print_verdict();
  end
endmodule
